// ==== core/bank_mul_pkg.sv ====
package bank_mul_pkg;

  // ****************************************
  // Opcode fields
  // ****************************************
  localparam logic [7:0] OP_LOAD_BANK = 8'h01;
  localparam logic [7:0] OP_MUL_LIT   = 8'h0d;
  localparam logic [6:0] OP_MUL_REG   = 7'h01;
  localparam int         OPC_HI       = 15;
  localparam int         OPC_LO       = 8;
  localparam int         ACCESS_BIT   = 8;
  localparam int         LIT_HI       = 7;
  localparam int         LIT_LO       = 0;
  localparam int         OPC_REG_LO   = 9;
  localparam int         LIT_W        = 8;
  localparam int         BANK_NIB_W   = 4;

  // ****************************************
  // Reset values and the fixed access bank
  // ****************************************
  localparam logic [7:0] BANK_RESET   = 8'h00;
  localparam logic [7:0] PROD_RESET   = 8'h00;
  localparam logic [3:0] ACCESS_BANK  = 4'h0;

endpackage

// ==== core/bank_select_and_multiply.sv ====
`timescale 1ns/10ps
module bank_select_and_multiply #(
  // Operand width, fixed by the eight-bit literal field
  parameter int DATA_W = 8,
  // Data-memory address: bank nibble above the file address
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              resetn,
  // Quarter-cycle enables from the core sequencer
  input  wire logic              q1En,
  input  wire logic              q2En,
  input  wire logic              q3En,
  input  wire logic              q4En,
  // Instruction word
  input  wire logic [15:0]       instrWord,
  // Working register value
  input  wire logic [DATA_W-1:0] workingRegister,
  // Data memory read port
  output logic      [ADDR_W-1:0] fileAddr,
  input  wire logic [DATA_W-1:0] fileData,
  // Results
  output logic      [DATA_W-1:0] bankSelectionRegister,
  output logic      [DATA_W-1:0] productHigh,
  output logic      [DATA_W-1:0] productLow,
  output logic                   productWrite
);

  // ****************************************
  // Derived sizes
  // ****************************************
  localparam int PROD_W = 2 * DATA_W;
  localparam int BANK_W = ADDR_W - DATA_W;

  // ****************************************
  // Elaboration checks
  // ****************************************
  // Literal and file address fields are eight bits wide in the opcode
  if (DATA_W != bank_mul_pkg::LIT_W) begin : gBadDataWidth
    $error("DATA_W must match the literal field of the opcode");
  end
  // Only the low bank nibble reaches the address; no wider bank space
  if (BANK_W != bank_mul_pkg::BANK_NIB_W) begin : gBadAddrWidth
    $error("ADDR_W must be DATA_W plus the bank nibble");
  end

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    KIND_NONE   = 4'h1,
    KIND_LOAD   = 4'h2,
    KIND_MULLIT = 4'h4,
    KIND_MULREG = 4'h8
  } op_kind_e;

  // ****************************************
  // Functions
  // ****************************************
  // Opcode decode; anything unknown falls to the idle kind
  function automatic op_kind_e decodeKind(logic [15:0] word);
    logic [7:0] high;
    logic [6:0] regHigh;
    high    = word[bank_mul_pkg::OPC_HI:bank_mul_pkg::OPC_LO];
    regHigh = word[bank_mul_pkg::OPC_HI:bank_mul_pkg::OPC_REG_LO];
    if (high == bank_mul_pkg::OP_LOAD_BANK) begin
      return KIND_LOAD;
    end else if (high == bank_mul_pkg::OP_MUL_LIT) begin
      return KIND_MULLIT;
    end else if (regHigh == bank_mul_pkg::OP_MUL_REG) begin
      return KIND_MULREG;
    end
    return KIND_NONE;
  endfunction

  // Both multiplies share the product write-back
  function automatic logic isMultiply(op_kind_e kind);
    return (kind == KIND_MULLIT) || (kind == KIND_MULREG);
  endfunction

  // Operands widened first so no high bits are lost
  function automatic logic [PROD_W-1:0] mulUnsigned(
    logic [DATA_W-1:0] a,
    logic [DATA_W-1:0] b
  );
    logic [PROD_W-1:0] wideA;
    logic [PROD_W-1:0] wideB;
    wideA = PROD_W'(a);
    wideB = PROD_W'(b);
    return wideA * wideB;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0]       instr_r;
  op_kind_e          kind_r;
  logic [DATA_W-1:0] operand_r;
  logic [PROD_W-1:0] product_r;
  logic [DATA_W-1:0] bank_r;
  logic [DATA_W-1:0] prodHi_r;
  logic [DATA_W-1:0] prodLo_r;
  logic              wr_r;

  // ****************************************
  // Next values and decode
  // ****************************************
  op_kind_e          kind_nxt;
  logic [DATA_W-1:0] operand_nxt;
  logic [PROD_W-1:0] product_nxt;
  logic [DATA_W-1:0] literalField;
  logic              accessBit;
  logic [BANK_W-1:0] bankNibble;
  logic              loadBank;
  logic              mulRegister;
  logic              writeBank;
  logic              writeProduct;

  assign kind_nxt     = decodeKind(instrWord);
  assign literalField = instr_r[bank_mul_pkg::LIT_HI:bank_mul_pkg::LIT_LO];
  assign accessBit    = instr_r[bank_mul_pkg::ACCESS_BIT];

  // Access bit 0 pins the access bank; 1 takes the bank register
  assign bankNibble = accessBit ? bank_r[BANK_W-1:0]
                                : bank_mul_pkg::ACCESS_BANK;
  assign fileAddr   = {bankNibble, literalField};

  // Register multiply reads the file byte; literal multiply its field
  assign operand_nxt = mulRegister ? fileData : literalField;
  assign product_nxt = mulUnsigned(workingRegister, operand_r);

  // Kind flags from the latched decode
  always_comb begin
    loadBank    = 1'h0;
    mulRegister = 1'h0;
    case (kind_r)
      KIND_LOAD: begin
        loadBank = 1'h1;
      end
      KIND_MULREG: begin
        mulRegister = 1'h1;
      end
      KIND_MULLIT: begin
        mulRegister = 1'h0;
      end
      KIND_NONE: begin
        loadBank = 1'h0;
      end
      default: begin
        loadBank    = 1'h0;
        mulRegister = 1'h0;
      end
    endcase
  end

  // Only Q4 commits; no flag or working register is ever written
  assign writeBank    = q4En && loadBank;
  assign writeProduct = q4En && isMultiply(kind_r);

  // ****************************************
  // Quarter pipeline
  // ****************************************
  // Q1 latch, Q2 operand read, Q3 multiply, Q4 write back
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      instr_r <= '0;
      kind_r  <= KIND_NONE;
    end else if (q1En) begin
      instr_r <= instrWord;
      kind_r  <= kind_nxt;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      operand_r <= '0;
    end else if (q2En) begin
      operand_r <= operand_nxt;
    end
  end

  // Working register is sampled at Q3, not at decode
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      product_r <= '0;
    end else if (q3En) begin
      product_r <= product_nxt;
    end
  end

  // ****************************************
  // Write back
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bank_r <= bank_mul_pkg::BANK_RESET;
    end else if (writeBank) begin
      bank_r <= literalField;
    end
  end

  // Both halves move together so a reader never sees a torn product
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prodHi_r <= bank_mul_pkg::PROD_RESET;
      prodLo_r <= bank_mul_pkg::PROD_RESET;
    end else if (writeProduct) begin
      prodHi_r <= product_r[PROD_W-1:DATA_W];
      prodLo_r <= product_r[DATA_W-1:0];
    end
  end

  // One-cycle strobe in the cycle after the Q4 edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_r <= 1'h0;
    end else begin
      wr_r <= writeProduct;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bankSelectionRegister = bank_r;
  assign productHigh           = prodHi_r;
  assign productLow            = prodLo_r;
  assign productWrite          = wr_r;

endmodule

// ==== verification/bank_select_and_multiply_checker.sv ====
`timescale 1ns/10ps
module bank_select_and_multiply_checker (
  input wire logic        clock, resetn, q2En, q4En, productWrite,
  input wire logic [15:0] instrWord,
  input wire logic [11:0] fileAddr,
  input wire logic [7:0]  workingRegister, fileData, bankSelectionRegister,
  input wire logic [7:0]  productHigh, productLow
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire [15:0] p  = {productHigh, productLow};
  wire [15:0] pl = workingRegister * instrWord[7:0];
  wire [15:0] pf = workingRegister * fileData;
  wire        lit = instrWord[15:8] == 8'h0d;
  wire        rm  = instrWord[15:9] == 7'h01;
  wire        lb  = q4En && instrWord[15:8] == 8'h01;
  sequence mulEnd; q4En && (lit || rm); endsequence
  sequence pulse; productWrite ##1 !productWrite; endsequence
  chk_lit_mul: assert property (
    productWrite && $past(lit) |-> p == $past(pl)) else $error("bad mul");
  chk_reg_mul: assert property (
    productWrite && $past(rm) |-> p == $past(pf)) else $error("bad mul");
  chk_bank_load: assert property (
    $past(lb) |-> bankSelectionRegister == $past(instrWord[7:0]))
    else $error("bad bank");
  chk_bank_keep: assert property (
    !$past(lb) |-> $stable(bankSelectionRegister)) else $error("bank moved");
  chk_write_pulse: assert property (
    mulEnd |=> pulse) else $error("bad write pulse");
  chk_stray_write: assert property (
    productWrite |-> $past(q4En && (lit || rm))) else $error("stray write");
  chk_file_addr: assert property (
    q2En && rm |-> fileAddr == {instrWord[8] ?
    bankSelectionRegister[3:0] : 4'h0, instrWord[7:0]}) else $error("addr");
  chk_prod_keep: assert property (
    !productWrite |-> $stable(p)) else $error("product moved");
endmodule
bind bank_select_and_multiply bank_select_and_multiply_checker chk (.*);

// ==== verification/bank_select_and_multiply_test.sv ====
`timescale 1ns/10ps
`define C(a,b) begin checked++; if ((a)!==(b)) begin errors++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module bank_select_and_multiply_test;
  localparam logic [7:0] OPS [5] = '{8'h01, 8'h0d, 8'h02, 8'h03, 8'h40};
  logic clock = 0, resetn = 0, q1En = 0, q2En = 0, q3En = 0, q4En = 0;
  logic        productWrite, m;
  logic [15:0] instrWord = 0, pr = 0;
  logic [7:0]  workingRegister = 0, fileData = 0, bk = 0;
  logic [7:0]  bankSelectionRegister, productHigh, productLow;
  logic [11:0] fileAddr;
  int          errors = 0, checked = 0;
  bank_select_and_multiply dut (.*);
  initial forever #12.5 clock = ~clock;
  function logic [15:0] xp(logic [15:0] i, logic [7:0] w, f);
    return w * (i[11] ? i[7:0] : f);
  endfunction
  task give_verdict;
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task op(logic [15:0] iw, logic [7:0] w, f);
    {instrWord, workingRegister, fileData} = {iw, w, f};
    for (int q = 0; q < 5; q++) begin
      @(posedge clock) #2 {q1En, q2En, q3En, q4En} = 4'b1000 >> q;
      if (q == 1 && iw[15:9] == 7'h01)
        `C(fileAddr, {iw[8] ? bk[3:0] : 4'h0, iw[7:0]})
    end
    m = iw[15:8] == 8'h0d || iw[15:9] == 7'h01;
    if (iw[15:8] == 8'h01) bk = iw[7:0];
    if (m) pr = xp(iw, w, f);
    `C(productWrite, m)
    `C({bankSelectionRegister, productHigh, productLow}, {bk, pr})
  endtask
  initial begin
    void'($urandom(10716));
    repeat (5) @(posedge clock);
    #2 resetn = 1;
    `C({bankSelectionRegister, productHigh, productLow}, 24'h0)
    op(16'h0105, 8'h00, 8'h00);
    op(16'h0dc4, 8'he2, 8'h00);
    op(16'h0312, 8'hc4, 8'hb5);
    op(16'h02ff, 8'hff, 8'hff);
    op(16'h0d00, 8'h7f, 8'h00);
    repeat (80)
      op({OPS[$urandom % 5], 8'($urandom)}, 8'($urandom), 8'($urandom));
    give_verdict;
  end
endmodule
